// >>> logic/rws_supervisor.sv
// Purpose: Processor supervisor: reset, low-line, watchdog, CE gate, overvoltage
// Assumes: Comparator results arrive as pin levels; one 40 MHz clock
// Notes: The CE gate is sampled, so it adds three cycles of delay
// Summary of operation
// - Reset stays asserted while supply is below reset threshold.
// - Manual reset input low asserts reset.
// - Reset held a further 200 ms after all causes clear.
// - During reset, watchdog counters clear and watchdog outputs sit high.
// - Active-high reset output is always the inverse of active-low.
// - Overvoltage flag low while sense above reference; nothing else affected.
// - Low-supply warning high normally, low below warning threshold.
// - Kick idle longer than timeout asserts pulse and fault outputs.
// - Any kick edge or pulse restarts the watchdog timer.
// - Supply below reset threshold disables watchdog, fault output high.
// - Fault falls 70 ns after pulse falls, stays low until a kick.
// - Each kickless timeout period gives a 1.7 ms low pulse.
// - Fault still high when pulse falls, for an external flip-flop.
// - Timeout select tied high picks the 1.6 s default.
// - Capacitor timeout is k times nF in ms, k 16.2 or 27.
// - CE low at reset entry: stay enabled until CE high or 15 us.
// - Outside reset, CE input transitions pass to CE output.
`timescale 1ns/100ps
module rws_supervisor
	import rws_pkg::*;
#(
	parameter int RESET_CYC = RESET_DELAY_CYC,
	parameter int WD_DEFAULT = WD_DEFAULT_CYC,
	parameter int PULSE_CYC = WD_PULSE_CYC,
	parameter int K5_CYC = K5_CYC_PER_NF,
	parameter int K3_CYC = K3_CYC_PER_NF
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic supply_low,
	input wire logic supply_warn,
	input wire logic manual_reset_n,
	input wire logic watchdog_kick_in,
	input wire logic timeout_select,
	input wire logic supply_is_5v,
	input wire logic [CAP_W-1:0] timeout_cap_nf,
	input wire logic overvoltage_sense,
	input wire logic ce_in_n,
	output logic sup_reset_n,
	output logic sup_reset,
	output logic lowline_n,
	output logic overvoltage_flag_n,
	output logic watchdog_fault_n,
	output logic watchdog_pulse_n,
	output logic ce_out_n,
	output logic ce_in_hiz
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	initial begin
		if (RESET_CYC < 1 || PULSE_CYC < 1 || WD_DEFAULT <= PULSE_CYC)
			$error("rws_supervisor: timing parameters out of range");
	end

	// ----------------------------------------------------------------
	// Input synchronisers and timeout select
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] sync_in;
	logic [SYNC_W-1:0] sync_out;
	logic low_s;
	logic warn_s;
	logic mr_n_s;
	logic kick_s;
	logic sel_s;
	logic v5_s;
	logic ov_s;
	logic ce_s;
	logic [CAP_W-1:0] cap_s;
	logic [CNT_W-1:0] period_cyc;

	assign sync_in = {timeout_cap_nf, ce_in_n, overvoltage_sense, supply_is_5v, timeout_select,
		watchdog_kick_in, manual_reset_n, supply_warn, supply_low};
	assign {cap_s, ce_s, ov_s, v5_s, sel_s, kick_s, mr_n_s, warn_s, low_s} = sync_out;

	rws_sync #(.W(SYNC_W)) u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.din(sync_in),
		.dout(sync_out)
	);

	// Default or capacitor-scaled period
	rws_period #(.WD_DEFAULT(WD_DEFAULT), .K5_CYC(K5_CYC), .K3_CYC(K3_CYC)) u_period (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.select_internal(sel_s),
		.supply_is_5v(v5_s),
		.cap_nf(cap_s),
		.period_cyc(period_cyc)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		rws_rst_state_t rst_state;
		logic [CNT_W-1:0] rst_cnt;
		logic [CNT_W-1:0] wd_cnt;
		logic [CNT_W-1:0] pulse_cnt;
		logic [3:0] fault_dly;
		logic kick_prev;
		logic gate_en;
		logic [15:0] hold_cnt;
		logic reset_n;
		logic reset;
		logic lowline_n;
		logic ov_n;
		logic fault_n;
		logic pulse_n;
		logic ce_out_n;
		logic ce_hiz;
	} rws_sup_st_t;

	rws_sup_st_t r;
	rws_sup_st_t next_r;
	logic rst_cause;
	logic rst_active;
	logic kick_edge;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;
		rst_cause = low_s || !mr_n_s;
		kick_edge = kick_s != r.kick_prev;
		next_r.kick_prev = kick_s;

		// Reset sequencer; any cause restarts the 200 ms hold-off
		unique case (r.rst_state)
			RWS_HOLD: begin
				if (!rst_cause) begin
					next_r.rst_state = RWS_DELAY;
					next_r.rst_cnt = CNT_W'(RESET_CYC - 1);
				end
			end
			RWS_DELAY: begin
				if (rst_cause) begin
					next_r.rst_state = RWS_HOLD;
				end else if (r.rst_cnt == CNT_ZERO) begin
					next_r.rst_state = RWS_RUN;
				end else begin
					next_r.rst_cnt = r.rst_cnt - 1'b1;
				end
			end
			RWS_RUN: begin
				if (rst_cause) begin
					next_r.rst_state = RWS_HOLD;
				end
			end
		endcase
		rst_active = next_r.rst_state != RWS_RUN;
		next_r.reset_n = !rst_active;
		next_r.reset = rst_active;

		// Independent comparators
		next_r.lowline_n = !warn_s;
		next_r.ov_n = !ov_s;

		// Watchdog; supply low always means reset, so it is disabled too
		if (rst_active) begin
			next_r.wd_cnt = CNT_ZERO;
			next_r.pulse_cnt = CNT_ZERO;
			next_r.fault_dly = 4'h0;
			next_r.fault_n = 1'b1;
			next_r.pulse_n = 1'b1;
		end else begin
			// Running pulse counts down first; a new timeout may restart it
			if (!r.pulse_n) begin
				if (r.pulse_cnt == CNT_ZERO) begin
					next_r.pulse_n = 1'b1;
				end else begin
					next_r.pulse_cnt = r.pulse_cnt - 1'b1;
				end
			end
			// Fault follows the pulse edge by the fixed delay
			if (r.fault_dly != 4'h0) begin
				next_r.fault_dly = r.fault_dly - 4'h1;
				if (r.fault_dly == 4'h1) begin
					next_r.fault_n = 1'b0;
				end
			end
			if (kick_edge) begin
				next_r.wd_cnt = CNT_ZERO;
				next_r.fault_n = 1'b1;
				next_r.fault_dly = 4'h0;
			end else if (r.wd_cnt >= period_cyc - 1'b1) begin
				next_r.wd_cnt = CNT_ZERO;
				next_r.pulse_n = 1'b0;
				next_r.pulse_cnt = CNT_W'(PULSE_CYC - 1);
				next_r.fault_dly = 4'(FAULT_DLY_CYC);
			end else begin
				next_r.wd_cnt = r.wd_cnt + 1'b1;
			end
		end

		// Chip-enable gate
		if (!rst_active) begin
			next_r.gate_en = 1'b1;
			next_r.hold_cnt = 16'h0000;
		end else if (r.reset_n) begin
			// Entering reset: a write in flight may finish
			next_r.gate_en = !ce_s;
			next_r.hold_cnt = 16'(CE_HOLD_CYC - 1);
		end else if (r.gate_en) begin
			if (ce_s || r.hold_cnt == 16'h0000) begin
				next_r.gate_en = 1'b0;
			end else begin
				next_r.hold_cnt = r.hold_cnt - 16'h0001;
			end
		end
		next_r.ce_out_n = next_r.gate_en ? ce_s : 1'b1;
		next_r.ce_hiz = !next_r.gate_en;
	end

	// ----------------------------------------------------------------
	// Register; reset holds the supervised system in reset
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			r.rst_state <= RWS_HOLD;
			r.rst_cnt <= CNT_ZERO;
			r.wd_cnt <= CNT_ZERO;
			r.pulse_cnt <= CNT_ZERO;
			r.fault_dly <= 4'h0;
			r.kick_prev <= 1'b0;
			r.gate_en <= 1'b0;
			r.hold_cnt <= 16'h0000;
			r.reset_n <= 1'b0;
			r.reset <= 1'b1;
			r.lowline_n <= 1'b1;
			r.ov_n <= 1'b1;
			r.fault_n <= 1'b1;
			r.pulse_n <= 1'b1;
			r.ce_out_n <= 1'b1;
			r.ce_hiz <= 1'b1;
		end else if (clk_en) begin
			r <= next_r;
		end
	end

	assign sup_reset_n = r.reset_n;
	assign sup_reset = r.reset;
	assign lowline_n = r.lowline_n;
	assign overvoltage_flag_n = r.ov_n;
	assign watchdog_fault_n = r.fault_n;
	assign watchdog_pulse_n = r.pulse_n;
	assign ce_out_n = r.ce_out_n;
	assign ce_in_hiz = r.ce_hiz;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_RST_COMPL: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sup_reset == !sup_reset_n) else $error("reset outputs not complementary");
	AST_RST_SUPPLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && low_s |=> !sup_reset_n) else $error("reset released with supply low");
	AST_RST_MR: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && !mr_n_s |=> !sup_reset_n) else $error("manual reset ignored");
	AST_RST_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(sup_reset_n) |-> $past(r.rst_state) == RWS_DELAY && $past(r.rst_cnt) == CNT_ZERO)
		else $error("reset released before hold-off ended");
	AST_WD_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!sup_reset_n |-> watchdog_fault_n && watchdog_pulse_n && r.wd_cnt == CNT_ZERO)
		else $error("watchdog active during reset");
	AST_CE_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ce_in_hiz |-> ce_out_n && !sup_reset_n) else $error("CE gate state wrong");
	AST_OVO: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en |=> overvoltage_flag_n == !$past(ov_s)) else $error("overvoltage flag wrong");
	AST_FAULT_AFTER_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(watchdog_pulse_n) && watchdog_fault_n |-> $past(watchdog_fault_n))
		else $error("fault fell before pulse");
	AST_FAULT_DELAY: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(watchdog_fault_n) |-> !watchdog_pulse_n && r.fault_dly == 4'h0)
		else $error("fault fell without pulse");
	AST_KICK_CLEARS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && kick_edge |=> watchdog_fault_n && r.wd_cnt == CNT_ZERO)
		else $error("kick did not restart watchdog");
	AST_CE_PASS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && sup_reset_n |=> sup_reset_n |-> ce_out_n == $past(ce_s))
		else $error("CE not passed outside reset");

	COV_TIMEOUT: cover property (@(posedge sys_clk) disable iff (!rst_n) $fell(watchdog_fault_n));
	COV_RELEASE: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(sup_reset_n));
	COV_CE_HOLD: cover property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(sup_reset_n) && !ce_in_hiz);
	COV_KICK: cover property (@(posedge sys_clk) disable iff (!rst_n) sup_reset_n && kick_edge);

endmodule : rws_supervisor

// >>> logic/rws_pkg.sv
// Purpose: Shared constants for the reset and watchdog supervisor
// Assumes: sys_clk at 40 MHz; comparator results arrive as digital levels
// Notes: Each time is kept in its own unit; cycle counts derive from it
package rws_pkg;

	// ----------------------------------------------------------------
	// Clock
	// ----------------------------------------------------------------
	localparam int SYS_CLK_HZ = 40_000_000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int CYC_PER_US = SYS_CLK_HZ / 1_000_000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int RESET_DELAY_MS = 200;
	localparam int RESET_DELAY_CYC = RESET_DELAY_MS * 1000 * CYC_PER_US;
	localparam int WD_DEFAULT_MS = 1600;
	localparam int WD_DEFAULT_CYC = WD_DEFAULT_MS * 1000 * CYC_PER_US;
	localparam int WD_PULSE_US = 1700;
	localparam int WD_PULSE_CYC = WD_PULSE_US * CYC_PER_US;
	localparam int CE_HOLD_US = 15;
	localparam int CE_HOLD_CYC = CE_HOLD_US * CYC_PER_US;
	localparam int FAULT_DLY_NS = 70;
	localparam int FAULT_DLY_CYC = (FAULT_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Capacitor timeout slope, microseconds per nF, at 5 V and 3 V
	localparam int K5_US_PER_NF = 16200;
	localparam int K3_US_PER_NF = 27000;
	localparam int K5_CYC_PER_NF = K5_US_PER_NF * CYC_PER_US;
	localparam int K3_CYC_PER_NF = K3_US_PER_NF * CYC_PER_US;
	// Smallest capacitor the slope holds for, in whole nF above 4.7 nF
	localparam logic [7:0] CAP_MIN_NF = 8'h05;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int CNT_W = 32;
	localparam int CAP_W = 8;
	localparam int SYNC_W = 8 + CAP_W;
	localparam logic [SYNC_W-1:0] SYNC_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ZERO = 32'h00000000;

	// Reset sequencer states
	typedef enum logic [1:0] {RWS_HOLD, RWS_DELAY, RWS_RUN} rws_rst_state_t;

endpackage : rws_pkg

// >>> logic/rws_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Multi-bit fields passing here are static straps
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
module rws_sync
	import rws_pkg::*;
#(
	parameter int W = SYNC_W
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} rws_sync_st_t;

	rws_sync_st_t r;
	rws_sync_st_t next_r;

	// ----------------------------------------------------------------
	// Stages
	// ----------------------------------------------------------------
	always_comb begin
		next_r.s1 = din;
		next_r.s2 = r.s1;
	end

	// Frozen with the rest of the block when clk_en is low
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			r <= '0;
		end else if (clk_en) begin
			r <= next_r;
		end
	end

	assign dout = r.s2;

endmodule : rws_sync

// >>> logic/rws_period.sv
// Purpose: Watchdog timeout length in clock cycles
// Assumes: Inputs already synchronised; capacitor size given in whole nF
// Notes: Registered, so a strap change takes effect one cycle later
`timescale 1ns/100ps
module rws_period
	import rws_pkg::*;
#(
	parameter int WD_DEFAULT = WD_DEFAULT_CYC,
	parameter int K5_CYC = K5_CYC_PER_NF,
	parameter int K3_CYC = K3_CYC_PER_NF
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic select_internal,
	input wire logic supply_is_5v,
	input wire logic [CAP_W-1:0] cap_nf,
	output logic [CNT_W-1:0] period_cyc
);

	typedef struct packed {
		logic [CNT_W-1:0] cyc;
	} rws_period_st_t;

	rws_period_st_t r;
	rws_period_st_t next_r;
	logic [CAP_W-1:0] cap_eff;
	logic [2*CNT_W-1:0] product;

	initial begin
		if (longint'(K3_CYC) * 255 >= 64'h0000_0001_0000_0000 || K5_CYC < 1 || WD_DEFAULT < 2)
			$error("rws_period: slope or default out of range");
	end

	// ----------------------------------------------------------------
	// Period select
	// ----------------------------------------------------------------
	// Tiny capacitors fall outside the slope, so clamp to the minimum
	always_comb begin
		cap_eff = (cap_nf < CAP_MIN_NF) ? CAP_MIN_NF : cap_nf;
		product = CNT_W'(supply_is_5v ? K5_CYC : K3_CYC) * {{(CNT_W-CAP_W){1'b0}}, cap_eff};
		next_r.cyc = select_internal ? CNT_W'(WD_DEFAULT) : product[CNT_W-1:0];
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			r.cyc <= CNT_W'(WD_DEFAULT);
		end else if (clk_en) begin
			r <= next_r;
		end
	end

	assign period_cyc = r.cyc;

endmodule : rws_period

// >>> verification/rws_host_model.sv
// Purpose: Processor and memory side model: watchdog kicks, manual reset wiring
// Assumes: Kick gap of 64 cycles sits inside every timeout the bench selects
// Notes: Holds the optional stop flip-flop and the fault-to-reset diode path
`timescale 1ns/100ps
module rws_host_model
	import rws_pkg::*;
(
	input wire logic sys_clk,
	input wire logic kick_on,
	input wire logic latch_on,
	input wire logic fault_to_mr,
	input wire logic mr_press_n,
	input wire logic watchdog_fault_n,
	input wire logic watchdog_pulse_n,
	output logic watchdog_kick_in,
	output logic manual_reset_n
);
	int gap;
	logic stop_q;

	initial begin
		watchdog_kick_in = 1'b0;
		stop_q = 1'b1;
		gap = 0;
	end

	// ----------------------------------------------------------------
	// Software kick
	// ----------------------------------------------------------------
	// Level toggles every 64 cycles while software is alive
	always @(posedge sys_clk) begin
		if (kick_on) begin
			gap <= (gap == 63) ? 0 : gap + 1;
			if (gap == 63) begin
				watchdog_kick_in <= #1 ~watchdog_kick_in;
			end
		end
	end

	// ----------------------------------------------------------------
	// Reset wiring
	// ----------------------------------------------------------------
	// Stop flop samples the fault level on each pulse fall; low only on the second fault
	always @(negedge watchdog_pulse_n or negedge latch_on) begin
		if (!latch_on) begin
			stop_q <= 1'b1;
		end else begin
			stop_q <= watchdog_fault_n;
		end
	end
	// Wired-OR of switch, stop flop and fault diode
	assign manual_reset_n = mr_press_n & (stop_q | ~latch_on) & (watchdog_fault_n | ~fault_to_mr);
endmodule : rws_host_model

// >>> verification/tb_reset_watchdog_supervisor.sv
// Purpose: Self-checking bench for the reset and watchdog supervisor
// Assumes: Shortened counts through parameters; clk_en dropped once to check the freeze
// Notes: Inputs move 1 ns after the rising edge and are sampled there
`timescale 1ns/100ps
`define check_eq(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
	$display("wrong value %s exp %0h got %0h", nm, exp, got); end end
module tb_reset_watchdog_supervisor
	import rws_pkg::*;
;
	localparam int RST_C = 50;
	localparam int WD_C = 300;
	localparam int PLS_C = 20;
	localparam int K5_C = 40;
	localparam int K3_C = 60;
	logic sys_clk, rst_n, supply_low, supply_warn, mr_press_n, timeout_select, supply_is_5v;
	logic overvoltage_sense, ce_in_n, kick_on, latch_on, fault_to_mr, clk_en;
	logic [CAP_W-1:0] timeout_cap_nf;
	logic manual_reset_n, watchdog_kick_in, sup_reset_n, sup_reset, lowline_n, overvoltage_flag_n;
	logic watchdog_fault_n, watchdog_pulse_n, ce_out_n, ce_in_hiz;
	int err_total, checks_done, n, p;

	rws_supervisor #(.RESET_CYC(RST_C), .WD_DEFAULT(WD_C), .PULSE_CYC(PLS_C), .K5_CYC(K5_C), .K3_CYC(K3_C)) i_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .supply_low(supply_low), .supply_warn(supply_warn),
		.manual_reset_n(manual_reset_n), .watchdog_kick_in(watchdog_kick_in), .timeout_select(timeout_select),
		.supply_is_5v(supply_is_5v), .timeout_cap_nf(timeout_cap_nf), .overvoltage_sense(overvoltage_sense),
		.ce_in_n(ce_in_n), .sup_reset_n(sup_reset_n), .sup_reset(sup_reset), .lowline_n(lowline_n),
		.overvoltage_flag_n(overvoltage_flag_n), .watchdog_fault_n(watchdog_fault_n),
		.watchdog_pulse_n(watchdog_pulse_n), .ce_out_n(ce_out_n), .ce_in_hiz(ce_in_hiz));

	rws_host_model i_host (.sys_clk(sys_clk), .kick_on(kick_on), .latch_on(latch_on), .fault_to_mr(fault_to_mr),
		.mr_press_n(mr_press_n), .watchdog_fault_n(watchdog_fault_n), .watchdog_pulse_n(watchdog_pulse_n),
		.watchdog_kick_in(watchdog_kick_in), .manual_reset_n(manual_reset_n));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task step(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask : step
	function automatic logic pick(input int k);
		case (k)
			0: return sup_reset_n;
			1: return watchdog_pulse_n;
			2: return watchdog_fault_n;
			default: return ce_in_hiz;
		endcase
	endfunction : pick
	// Bounded wait for an output level; cnt is the cycles spent
	task wait_on(input int k, input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while (pick(k) !== lvl && cnt < lim) begin
			step(1);
			cnt++;
		end
	endtask : wait_on
	// Fall-to-fall distance of the watchdog pulse
	task period_of(output int per);
		int a, b, c;
		wait_on(1, 1'b0, 1000, a);
		step(1);
		wait_on(1, 1'b1, 1000, b);
		wait_on(1, 1'b0, 1000, c);
		per = 1 + b + c;
	endtask : period_of
	task release_wait;
		wait_on(0, 1'b1, RST_C + 10, n);
		`check_eq("hold", 1'b1, (n >= RST_C && n <= RST_C + 4))
		`check_eq("reset_hi", 1'b0, sup_reset)
	endtask : release_wait

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_release;
		`check_eq("hiz", 1'b1, ce_in_hiz)
		`check_eq("ce_out", 1'b1, ce_out_n)
		`check_eq("wd_out", 2'b11, {watchdog_fault_n, watchdog_pulse_n})
		release_wait();
	endtask : t_release
	task t_supply;
		kick_on = 1'b0;
		supply_low = 1'b1;
		step(4);
		`check_eq("reset_lo", 1'b0, sup_reset_n)
		`check_eq("reset_hi", 1'b1, sup_reset)
		step(WD_C + 50);
		`check_eq("still", 1'b0, sup_reset_n)
		`check_eq("wd_idle", 2'b11, {watchdog_fault_n, watchdog_pulse_n})
		supply_low = 1'b0;
		kick_on = 1'b1;
		release_wait();
		mr_press_n = 1'b0;
		wait_on(0, 1'b0, 8, n);
		`check_eq("mr", 1'b0, sup_reset_n)
		step(4);
		mr_press_n = 1'b1;
		release_wait();
	endtask : t_supply
	task t_watchdog;
		step(3 * WD_C);
		`check_eq("kicked", 2'b11, {watchdog_fault_n, watchdog_pulse_n})
		kick_on = 1'b0;
		wait_on(1, 1'b0, WD_C + 80, n);
		`check_eq("pulse", 1'b0, watchdog_pulse_n)
		`check_eq("fault_pre", 1'b1, watchdog_fault_n)
		step(FAULT_DLY_CYC - 1);
		`check_eq("fault_dly", 1'b1, watchdog_fault_n)
		step(1);
		`check_eq("fault", 1'b0, watchdog_fault_n)
		wait_on(1, 1'b1, PLS_C, n);
		`check_eq("width", PLS_C - FAULT_DLY_CYC, n)
		wait_on(1, 1'b0, WD_C, n);
		`check_eq("period", WD_C - PLS_C, n)
		`check_eq("fault_held", 1'b0, watchdog_fault_n)
		kick_on = 1'b1;
		wait_on(2, 1'b1, 100, n);
		`check_eq("clear", 1'b1, n <= 68)
	endtask : t_watchdog
	task t_period;
		int exp_p[4];
		exp_p = '{6 * K5_C, 6 * K3_C, 5 * K5_C, WD_C};
		for (int i = 0; i < 4; i++) begin
			supply_low = 1'b1;
			timeout_select = (i == 3);
			supply_is_5v = (i != 1);
			timeout_cap_nf = (i == 2) ? 8'h02 : 8'h06;
			step(5);
			supply_low = 1'b0;
			kick_on = 1'b0;
			release_wait();
			period_of(p);
			period_of(p);
			`check_eq("strap_period", exp_p[i], p)
		end
		// Clear the standing fault so the next scenario starts clean
		kick_on = 1'b1;
		wait_on(2, 1'b1, 100, n);
		`check_eq("refault", 1'b1, watchdog_fault_n)
	endtask : t_period
	task t_levels;
		// Frozen clock enable must hold every flop, sync stages too
		clk_en = 1'b0;
		supply_warn = 1'b1;
		step(6);
		`check_eq("frozen", 1'b1, lowline_n)
		clk_en = 1'b1;
		step(4);
		`check_eq("lowline", 1'b0, lowline_n)
		supply_warn = 1'b0;
		overvoltage_sense = 1'b1;
		step(4);
		`check_eq("lowline", 1'b1, lowline_n)
		`check_eq("ov", 2'b01, {overvoltage_flag_n, sup_reset_n})
		overvoltage_sense = 1'b0;
		step(4);
		`check_eq("ov", 1'b1, overvoltage_flag_n)
	endtask : t_levels
	task t_ce;
		ce_in_n = 1'b0;
		step(3);
		`check_eq("ce_pass", 1'b0, ce_out_n)
		supply_low = 1'b1;
		step(300);
		`check_eq("ce_hold", 1'b0, ce_in_hiz)
		// Gate cuts 600 cycles after reset entry, which lags the pin by 3
		wait_on(3, 1'b1, 400, n);
		`check_eq("ce_15us", CE_HOLD_CYC - 297, n)
		`check_eq("ce_cut", 2'b11, {ce_in_hiz, ce_out_n})
		ce_in_n = 1'b1;
		step(4);
		ce_in_n = 1'b0;
		step(4);
		`check_eq("ce_ignored", 1'b1, ce_out_n)
		supply_low = 1'b0;
		release_wait();
		step(4);
		supply_low = 1'b1;
		step(50);
		`check_eq("ce_hold", 1'b0, ce_in_hiz)
		ce_in_n = 1'b1;
		wait_on(3, 1'b1, 8, n);
		`check_eq("ce_early", 1'b1, n <= 4)
		supply_low = 1'b0;
		release_wait();
		`check_eq("ce_pass", 2'b01, {ce_in_hiz, ce_out_n})
	endtask : t_ce
	task t_external;
		kick_on = 1'b0;
		latch_on = 1'b1;
		wait_on(0, 1'b0, 2 * WD_C + 60, n);
		`check_eq("two_faults", 1'b1, n > WD_C)
		step(RST_C + 100);
		`check_eq("latched", 1'b0, sup_reset_n)
		latch_on = 1'b0;
		release_wait();
		fault_to_mr = 1'b1;
		wait_on(0, 1'b0, WD_C + 60, n);
		`check_eq("fault_rst", 2'b10, {watchdog_fault_n, sup_reset_n})
		fault_to_mr = 1'b0;
		kick_on = 1'b1;
		release_wait();
	endtask : t_external

	// ----------------------------------------------------------------
	// Sequence and verdict
	// ----------------------------------------------------------------
	task print_verdict;
		if (err_total == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict
	// Cut a hang well past the expected 8k cycles
	initial begin
		repeat (60000) @(posedge sys_clk);
		err_total++;
		print_verdict();
	end
	initial begin
		{err_total, checks_done} = '0;
		{rst_n, supply_low, supply_warn, overvoltage_sense, ce_in_n, latch_on, fault_to_mr} = 7'h04;
		clk_en = 1'b1;
		{mr_press_n, timeout_select, supply_is_5v, kick_on} = 4'hF;
		timeout_cap_nf = 8'h06;
		rst_n = 1'b0;
		step(20);
		rst_n = 1'b1;
		t_release();
		t_supply();
		t_watchdog();
		t_levels();
		t_ce();
		t_period();
		t_external();
		print_verdict();
	end
endmodule : tb_reset_watchdog_supervisor
